// ### rtl/cmcr_pkg.sv
// package: register map, field layout, reset values and divider sizes of the config bank
package cmcr_pkg;

   // ----------------------------------------------------------------
   // bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16;                 // byte address width on the bus
   localparam int DATA_W = 32;                 // bus data width
   localparam int INDEX_W = 14;                // register index width (byte address / 4)

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [13:0] MUX_CONFIG_INDEX = 14'h2002;   // holds mux_state_count
   localparam logic [13:0] CPU_CLOCK_INDEX = 14'h2004;    // holds cpu_clock_divide
   localparam logic [13:0] MUX_CONTROL_INDEX = 14'h2005;  // sync_pin_enable, alternate_input_select
   localparam logic [13:0] SEGMENT_37_INDEX = 14'h2055;   // segment_pattern_thirty_seven

   // ----------------------------------------------------------------
   // field positions inside the low data byte
   // ----------------------------------------------------------------
   localparam int MUX_STATE_COUNT_LSB = 6;     // two bits, 7:6
   localparam int CPU_DIVIDE_LSB = 0;          // three bits, 2:0
   localparam int SYNC_ENABLE_BIT = 0;         // bit 0
   localparam int ALTERNATE_INPUT_BIT = 2;     // bit 2
   localparam int SEGMENT_PATTERN_LSB = 0;     // four bits, 3:0

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] MUX_STATE_COUNT_RESET = 2'h0;
   localparam logic [2:0] CPU_DIVIDE_RESET = 3'h0;        // undivided at power-up
   localparam logic SYNC_ENABLE_RESET = 1'b0;
   localparam logic ALTERNATE_INPUT_RESET = 1'b0;
   localparam logic [3:0] SEGMENT_PATTERN_RESET = 4'h0;

   // ----------------------------------------------------------------
   // multiplexer state count decode
   // ----------------------------------------------------------------
   localparam logic [1:0] MUX_CODE_SIX = 2'h0;
   localparam logic [1:0] MUX_CODE_FOUR = 2'h1;
   localparam logic [1:0] MUX_CODE_THREE = 2'h2;
   localparam logic [1:0] MUX_CODE_TWO = 2'h3;
   localparam logic [2:0] MUX_STATES_SIX = 3'h6;
   localparam logic [2:0] MUX_STATES_FOUR = 3'h4;
   localparam logic [2:0] MUX_STATES_THREE = 3'h3;
   localparam logic [2:0] MUX_STATES_TWO = 3'h2;

   // ----------------------------------------------------------------
   // divider and bus answers
   // ----------------------------------------------------------------
   localparam int DIVIDE_COUNT_W = 7;          // counts up to 2^7 - 1
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : cmcr_pkg

// ### rtl/cmcr_clock_divider.sv
// module: glitch-free power-of-two clock enable divider for the processor clock
module cmcr_clock_divider
   import cmcr_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [2:0] divide_request,
   output logic [2:0] divide_active,
   output logic clock_enable
);

   // ----------------------------------------------------------------
   // period counter
   // ----------------------------------------------------------------
   logic [DIVIDE_COUNT_W-1:0] period_count;    // cycles into current period
   logic [DIVIDE_COUNT_W-1:0] period_limit;    // last count of the period
   logic period_end;                           // final cycle of the period

   // limit is 2^divide - 1, from the setting in force
   assign period_limit = DIVIDE_COUNT_W'((1 << divide_active) - 1);
   assign period_end = (period_count == period_limit);

   // counter wraps at the period end only
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         period_count <= '0;
      end else if (period_end) begin
         period_count <= '0;
      end else begin
         period_count <= period_count + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // setting in force
   // ----------------------------------------------------------------
   // a new ratio takes over only at a period boundary, so no period is
   // cut short or stretched oddly: no runt or lost processor edge
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         divide_active <= CPU_DIVIDE_RESET;
      end else if (period_end) begin
         divide_active <= divide_request;
      end
   end

   // ----------------------------------------------------------------
   // enable pulse, one cycle per period
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         clock_enable <= 1'b0;
      end else begin
         clock_enable <= period_end;
      end
   end

endmodule : cmcr_clock_divider

// ### rtl/cmcr_regs.sv
// module: processor-facing config bank for clock divide, input multiplexer and segment patterns
//
// What this block does
// - processor clock is engine clock over 2^divide
// - divide field clears to zero at power-up
// - divide changes anytime, without glitches or lost edges
// - alternate-input bit steers conversions to alternate inputs
// - state-count code gives six, four, three, two
// - sync enable turns segment seven into sync
// - pattern bit n drives segment in phase n
module cmcr_regs
   import cmcr_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   // axi4-lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // processor clock enable
   output logic cpu_clock_enable,
   output logic [2:0] cpu_clock_divide,
   // input multiplexer controls
   output logic [1:0] mux_state_count,
   output logic [2:0] mux_state_total,
   output logic alternate_input_select,
   // segment seven pin sharing
   input wire logic multiplexer_sync_output,
   input wire logic segment_seven_drive,
   output logic segment_pin_seven,
   // segment thirty-seven time-division drive
   input wire logic [1:0] common_phase,
   output logic segment_thirty_seven_drive
);

   // ----------------------------------------------------------------
   // stored fields
   // ----------------------------------------------------------------
   logic [1:0] state_count_field;              // written state-count code
   logic [2:0] divide_field;                   // requested processor ratio
   logic sync_enable_field;                    // segment seven repurpose
   logic alternate_field;                      // alternate input set
   logic [3:0] segment_37_field;               // pattern over four phases

   // ----------------------------------------------------------------
   // write channel bookkeeping
   // ----------------------------------------------------------------
   logic aw_held;                              // address taken, not yet used
   logic w_held;                               // data taken, not yet used
   logic [INDEX_W-1:0] write_index;            // held word index
   logic [7:0] write_byte;                     // held low data byte
   logic write_lane;                           // low byte lane enabled
   logic write_fire;                           // both halves present
   logic write_hit;                            // index maps to a register

   // ----------------------------------------------------------------
   // read channel bookkeeping
   // ----------------------------------------------------------------
   logic [INDEX_W-1:0] read_index;             // index of incoming read
   logic [DATA_W-1:0] read_word;               // decoded read value
   logic read_hit;                             // index maps to a register

   // the write happens once address and data are both in hand and
   // the previous response has been taken
   assign write_fire = aw_held && w_held && !s_axi_bvalid;

   // ----------------------------------------------------------------
   // write address channel
   // ----------------------------------------------------------------
   // ready drops on the handshake and returns after the response, so
   // only one write is ever under way
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_awready <= 1'b0;
         aw_held <= 1'b0;
         write_index <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_held <= 1'b1;
         write_index <= s_axi_awaddr[ADDR_W-1:2];
      end else if (write_fire) begin
         aw_held <= 1'b0;
      end else if (!aw_held && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // write data channel
   // ----------------------------------------------------------------
   // taken independently of the address, in either order
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_wready <= 1'b0;
         w_held <= 1'b0;
         write_byte <= '0;
         write_lane <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_held <= 1'b1;
         write_byte <= s_axi_wdata[7:0];
         write_lane <= s_axi_wstrb[0];
      end else if (write_fire) begin
         w_held <= 1'b0;
      end else if (!w_held && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   always_comb begin
      unique case (write_index)
         MUX_CONFIG_INDEX,
         CPU_CLOCK_INDEX,
         MUX_CONTROL_INDEX,
         SEGMENT_37_INDEX: write_hit = 1'b1;
         default: write_hit = 1'b0;      // unmapped word
      endcase
   end

   // ----------------------------------------------------------------
   // write response
   // ----------------------------------------------------------------
   // unmapped words answer slverr and change nothing
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (write_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= write_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // field storage
   // ----------------------------------------------------------------
   // all fields sit in byte lane 0; a write without that lane keeps them
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_count_field <= MUX_STATE_COUNT_RESET;
         divide_field <= CPU_DIVIDE_RESET;
         sync_enable_field <= SYNC_ENABLE_RESET;
         alternate_field <= ALTERNATE_INPUT_RESET;
         segment_37_field <= SEGMENT_PATTERN_RESET;
      end else if (write_fire && write_lane) begin
         unique case (write_index)
            MUX_CONFIG_INDEX: begin
               state_count_field <= write_byte[MUX_STATE_COUNT_LSB +: 2];
            end
            CPU_CLOCK_INDEX: begin
               divide_field <= write_byte[CPU_DIVIDE_LSB +: 3];
            end
            MUX_CONTROL_INDEX: begin
               sync_enable_field <= write_byte[SYNC_ENABLE_BIT];
               alternate_field <= write_byte[ALTERNATE_INPUT_BIT];
            end
            SEGMENT_37_INDEX: begin
               segment_37_field <= write_byte[SEGMENT_PATTERN_LSB +: 4];
            end
            default: begin
               // unmapped word: nothing stored
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // read decode
   // ----------------------------------------------------------------
   assign read_index = s_axi_araddr[ADDR_W-1:2];

   // fields read back in place; other bits read zero
   always_comb begin
      read_word = '0;
      read_hit = 1'b1;
      unique case (read_index)
         MUX_CONFIG_INDEX: begin
            read_word[MUX_STATE_COUNT_LSB +: 2] = state_count_field;
         end
         CPU_CLOCK_INDEX: begin
            read_word[CPU_DIVIDE_LSB +: 3] = divide_field;
         end
         MUX_CONTROL_INDEX: begin
            read_word[SYNC_ENABLE_BIT] = sync_enable_field;
            read_word[ALTERNATE_INPUT_BIT] = alternate_field;
         end
         SEGMENT_37_INDEX: begin
            read_word[SEGMENT_PATTERN_LSB +: 4] = segment_37_field;
         end
         default: begin
            read_hit = 1'b0;                   // unmapped: zero data, slverr
         end
      endcase
   end

   // ----------------------------------------------------------------
   // read channels
   // ----------------------------------------------------------------
   // one read at a time: ready is low while an answer is waiting
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= read_word;
         s_axi_rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // processor clock divider
   // ----------------------------------------------------------------
   // the divider reports the ratio in force, which trails a write
   // until the running period ends
   cmcr_clock_divider u_divider (
      .core_clk(core_clk),
      .resetn(resetn),
      .divide_request(divide_field),
      .divide_active(cpu_clock_divide),
      .clock_enable(cpu_clock_enable)
   );

   // ----------------------------------------------------------------
   // multiplexer controls
   // ----------------------------------------------------------------
   // registered so the multiplexer sees clean levels
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mux_state_count <= MUX_STATE_COUNT_RESET;
         alternate_input_select <= ALTERNATE_INPUT_RESET;
      end else begin
         mux_state_count <= state_count_field;
         alternate_input_select <= alternate_field;
      end
   end

   // state count code to number of states per cycle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mux_state_total <= MUX_STATES_SIX;
      end else begin
         unique case (state_count_field)
            MUX_CODE_SIX: mux_state_total <= MUX_STATES_SIX;
            MUX_CODE_FOUR: mux_state_total <= MUX_STATES_FOUR;
            MUX_CODE_THREE: mux_state_total <= MUX_STATES_THREE;
            MUX_CODE_TWO: mux_state_total <= MUX_STATES_TWO;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // segment seven pin sharing
   // ----------------------------------------------------------------
   // both sources come from logic on this clock, so no synchroniser;
   // the pin lags its source by one cycle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         segment_pin_seven <= 1'b0;
      end else if (sync_enable_field) begin
         segment_pin_seven <= multiplexer_sync_output;
      end else begin
         segment_pin_seven <= segment_seven_drive;
      end
   end

   // ----------------------------------------------------------------
   // segment thirty-seven phase drive
   // ----------------------------------------------------------------
   // pattern bit n is the segment state during common phase n
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         segment_thirty_seven_drive <= 1'b0;
      end else begin
         segment_thirty_seven_drive <= segment_37_field[common_phase];
      end
   end

endmodule : cmcr_regs

// ### sim/cmcr_regs_assertions.sv
// checker: bus, divider and field-follow properties of the config bank
module cmcr_regs_assertions
   import cmcr_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic cpu_clock_enable,
   input wire logic [2:0] cpu_clock_divide,
   input wire logic [1:0] mux_state_count,
   input wire logic [2:0] mux_state_total,
   input wire logic alternate_input_select
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // shadow of the last accepted field writes
   // ----------------------------------------------------------------
   wire logic wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; // both taken together
   logic [2:0] want_div; // divide last written
   logic [1:0] want_cnt; // state count last written
   logic want_alt; // alternate bit last written
   logic [8:0] lag_cnt; // cycles the divide trails its write
   // capture on the write handshake, low byte only
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         want_div <= 3'h0;
         want_cnt <= 2'h0;
         want_alt <= 1'b0;
      end else if (wr_go && s_axi_wstrb[0]) begin
         if (s_axi_awaddr == 16'h8010) want_div <= s_axi_wdata[2:0];
         if (s_axi_awaddr == 16'h8008) want_cnt <= s_axi_wdata[7:6];
         if (s_axi_awaddr == 16'h8014) want_alt <= s_axi_wdata[2];
      end
   end
   // longest legal wait is two full slow periods plus bus latency
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) lag_cnt <= 9'h0;
      else if (cpu_clock_divide == want_div) lag_cnt <= 9'h0;
      else lag_cnt <= lag_cnt + 9'h1;
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking dcb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   a_enable_every: assert property (
      cpu_clock_divide == 3'h0 && $past(cpu_clock_divide) == 3'h0 && $past(cpu_clock_enable) |-> cpu_clock_enable)
      else $error("enable dropped at divide zero");
   a_enable_period: assert property (
      cpu_clock_enable && cpu_clock_divide == 3'h2 && $past(cpu_clock_divide, 8) == 3'h2 |-> !$past(cpu_clock_enable)
      && !$past(cpu_clock_enable, 2) && !$past(cpu_clock_enable, 3) && $past(cpu_clock_enable, 4))
      else $error("enable period not four at divide two");
   a_divide_adopt: assert property (lag_cnt < 9'h118)
      else $error("divide did not follow write");
   a_total_decode: assert property (
      $past(mux_state_count) == mux_state_count && $past(mux_state_count, 2) == mux_state_count
      |-> mux_state_total == (mux_state_count == 2'h0 ? 3'h6 : mux_state_count == 2'h1 ? 3'h4
      : mux_state_count == 2'h2 ? 3'h3 : 3'h2)) else $error("state total wrong");
   a_count_follow: assert property ($past(want_cnt, 4) == want_cnt |-> mux_state_count == want_cnt)
      else $error("state count not written value");
   a_alt_follow: assert property ($past(want_alt, 4) == want_alt |-> alternate_input_select == want_alt)
      else $error("alternate select not written value");
   a_write_answer: assert property (wr_go |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write ready while answer pending");
endmodule : cmcr_regs_assertions

bind cmcr_regs cmcr_regs_assertions u_cmcr_regs_assertions (.*);

// ### sim/cmcr_regs_tb_top.sv
// testbench: config bank register, divider and pin-sharing checks
module cmcr_regs_tb_top
   import cmcr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, resetn = 1'b0;
   logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, cpu_clock_divide, mux_state_total;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, mux_state_count, r, common_phase = 2'h0;
   logic multiplexer_sync_output = 1'b0, segment_seven_drive = 1'b0;
   logic cpu_clock_enable, alternate_input_select, segment_pin_seven, segment_thirty_seven_drive;
   int err_count = 0, n_checks = 0, cnt, n;
   // table rows: address, write value, read-back, expected state total (0 = skip)
   typedef struct {logic [15:0] a; logic [31:0] w; logic [31:0] rd; logic [2:0] tot;} cmcr_row_type;
   cmcr_row_type rows [10] = '{'{16'h8008, 32'h40, 32'h40, 3'h4}, '{16'h8008, 32'h80, 32'h80, 3'h3},
      '{16'h8008, 32'hFFFFFFFF, 32'hC0, 3'h2}, '{16'h8008, 32'h0, 32'h0, 3'h6}, '{16'h8014, 32'h5, 32'h5, 3'h0},
      '{16'h8014, 32'hFFFFFFFA, 32'h0, 3'h0}, '{16'h8154, 32'hF, 32'hF, 3'h0}, '{16'h8154, 32'hFFFFFFF6, 32'h6, 3'h0},
      '{16'h8010, 32'h3, 32'h3, 3'h0}, '{16'h8010, 32'h0, 32'h0, 3'h0}};
   always #12.5 core_clk = ~core_clk;
   cmcr_regs u_cmcr_regs (.*);
   // ----------------------------------------------------------------
   // compare, bus and closing tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // address and data offered together, each released when taken
   task automatic axi_wr(input logic [15:0] a, input logic [31:0] dv, input logic [3:0] s);
      bit got = 0;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dv;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!got) begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            got = 1;
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
         end
      end
   endtask : axi_wr
   task automatic axi_rd(input logic [15:0] a);
      bit got = 0;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!got) begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            got = 1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
         end
      end
   endtask : axi_rd
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk("divide_reset", 32'(cpu_clock_divide), 32'h0);
      axi_rd(16'h8010);
      chk("divide_read", d, 32'h0);
      $display("test reset done");
      foreach (rows[i]) begin
         axi_wr(rows[i].a, rows[i].w, 4'hF);
         chk("wr_resp", 32'(r), 32'h0);
         axi_rd(rows[i].a);
         chk("rd_data", d, rows[i].rd);
         if (rows[i].tot != 3'h0) chk("state_total", 32'(mux_state_total), 32'(rows[i].tot));
      end
      $display("test table done");
      // every divide code: pulses in 256 cycles, whatever the phase
      for (int k = 0; k < 8; k++) begin
         axi_wr(16'h8010, k, 4'hF);
         for (n = 0; n < 300 && cpu_clock_divide !== 3'(k); n++) @(posedge core_clk);
         cnt = 0;
         repeat (256) begin
            @(posedge core_clk);
            if (cpu_clock_enable === 1'b1) cnt++;
         end
         chk("enable_count", cnt, 256 >> k);
      end
      // switch from the slowest ratio back mid-period
      axi_wr(16'h8010, 32'h0, 4'hF);
      for (n = 0; n < 300 && cpu_clock_divide !== 3'h0; n++) @(posedge core_clk);
      chk("divide_back", 32'(cpu_clock_divide), 32'h0);
      $display("test divider done");
      axi_wr(16'h8014, 32'h5, 4'hF);
      multiplexer_sync_output <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk("alt_on", 32'(alternate_input_select), 32'h1);
      chk("segment_pin_seven_sync_hi", 32'(segment_pin_seven), 32'h1);
      multiplexer_sync_output <= 1'b0;
      segment_seven_drive <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk("segment_pin_seven_sync_lo", 32'(segment_pin_seven), 32'h0);
      axi_wr(16'h8014, 32'h0, 4'hF);
      repeat (3) @(posedge core_clk);
      chk("segment_pin_seven_segment", 32'(segment_pin_seven), 32'h1);
      chk("alt_off", 32'(alternate_input_select), 32'h0);
      $display("test pin sharing done");
      axi_wr(16'h8154, 32'hA, 4'hF);
      for (int p = 0; p < 4; p++) begin
         common_phase <= 2'(p);
         repeat (3) @(posedge core_clk);
         chk("seg37_phase", 32'(segment_thirty_seven_drive), (32'hA >> p) & 32'h1);
      end
      $display("test pattern done");
      axi_wr(16'h9000, 32'hFF, 4'hF);
      chk("unmapped_wr", 32'(r), 32'h2);
      axi_rd(16'h9000);
      chk("unmapped_rd", 32'(r), 32'h2);
      axi_wr(16'h8154, 32'h5, 4'h0);
      axi_rd(16'h8154);
      chk("strobe_off", d, 32'hA);
      $display("test refusals done");
      // second reset mid-run clears the fields again
      axi_wr(16'h8010, 32'h5, 4'hF);
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      axi_rd(16'h8154);
      chk("pattern_reset", d, 32'h0);
      chk("divide_reset2", 32'(cpu_clock_divide), 32'h0);
      $display("test second reset done");
      end_sim();
   end
   // watchdog: the sequence needs well under 6000 cycles
   initial begin
      repeat (30000) @(posedge core_clk);
      err_count++;
      end_sim();
   end
endmodule : cmcr_regs_tb_top
